/* File: rtl/mux_pkg.sv */
// Shared constants for the eight-line serial multiplexer data path
package mux_pkg;
    localparam int LINES = 8;
    localparam int FIFO_DEPTH = 49;
    localparam int WORD_W = 16;
    localparam int DIV_W = 12;
    localparam int FMT_W = 18;
    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_FORMAT = 8'h04;
    localparam logic [7:0] OFF_RXWORD = 8'h08;
    localparam logic [7:0] OFF_TXDATA = 8'h0C;
    localparam logic [7:0] OFF_MODEM_OUT = 8'h10;
    localparam logic [7:0] OFF_MODEM_IN = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // Format write: [2:0] line, stored fields from bit 3 up
    localparam int FMT_LSB = 3;
    localparam int F_LEN = 0;
    localparam int F_PEN = 2;
    localparam int F_ODD = 3;
    localparam int F_TWO = 4;
    localparam int F_HALF = 5;
    localparam int F_DIV = 6;
    // Receive entry layout
    localparam int E_LINE = 8;
    localparam int E_PERR = 11;
    localparam int E_FERR = 12;
    localparam int E_VALID = 15;
    // Transmit word, modem and status layouts
    localparam int TX_CHAR = 8;
    localparam int M_DTR = 0;
    localparam int M_RTS = 8;
    localparam int M_SEC = 16;
    localparam int M_CTS = 0;
    localparam int M_CAR = 8;
    localparam int M_SRX = 16;
    localparam int M_RING = 24;
    localparam int S_FULL = 6;
    localparam int S_TEST = 7;
    localparam int S_TXP = 8;
    // Sample tick points within a bit
    localparam logic [3:0] MID_START = 4'h7;
    localparam logic [3:0] BIT_END = 4'hF;
endpackage : mux_pkg

/* File: rtl/line_uart.sv */
// One line: 16x receiver and double-buffered transmitter
module line_uart (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Line format
    input wire logic [11:0] div_in,
    input wire logic [1:0] len_in,
    input wire logic par_en_in,
    input wire logic par_odd_in,
    input wire logic two_stop_in,
    input wire logic half_in,
    input wire logic en_in,
    // Serial pins
    input wire logic rxd_in,
    output logic txd_out,
    // Scanner side
    input wire logic rx_ack_in,
    output logic rx_rdy_out,
    output logic [7:0] rx_data_out,
    output logic rx_perr_out,
    output logic rx_ferr_out,
    input wire logic tx_load_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_empty_out
);
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
    } rx_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;

    // Data mask for 5..8 bit characters
    function automatic logic [7:0] len_mask(input logic [1:0] len);
        len_mask = 8'hFF >> (2'd3 - len);
    endfunction : len_mask

    logic [11:0] div_r;
    logic [1:0] sync_r;
    rx_state_t rx_r;
    logic [3:0] rsub_r;
    logic [3:0] rbit_r;
    logic [8:0] sh_r;
    logic blind_r;
    logic rdy_r;
    logic [7:0] data_r;
    logic perr_r;
    logic ferr_r;
    tx_state_t tx_r;
    logic [3:0] tsub_r;
    logic [3:0] left_r;
    logic [11:0] fr_r;
    logic [7:0] hold_r;
    logic full_r;

    wire tick = (div_r == 12'h000);
    wire rxd = sync_r[1];
    wire rx_en = en_in | half_in;
    wire [3:0] nbits = {2'b00, len_in} + 4'h5;
    wire [3:0] last_bit = nbits - {3'b000, ~par_en_in};
    wire [7:0] rx_dm = sh_r[7:0] & len_mask(len_in);
    wire rx_pbit = sh_r[nbits];
    wire rx_perr = par_en_in & ((^rx_dm ^ rx_pbit) != par_odd_in);
    wire rx_done = (rx_r == RX_STOP) & tick & (rsub_r == mux_pkg::BIT_END);
    wire rx_take = rx_done & ~blind_r & (~rdy_r | rx_ack_in);
    wire tx_busy = (tx_r == TX_SHIFT);
    wire bit_end = tx_busy & tick & (tsub_r == mux_pkg::BIT_END);
    wire tx_start = full_r & en_in & ((tx_r == TX_IDLE) | (bit_end & (left_r == 4'h1)));
    wire [7:0] tx_dm = hold_r & len_mask(len_in);
    wire tx_pbit = (^tx_dm) ^ par_odd_in;
    wire [11:0] fr_base = {3'b111, 8'hFF & ~len_mask(len_in) | tx_dm, 1'b0};
    wire [11:0] pmask = 12'h001 << (nbits + 4'h1);
    wire [11:0] fr_new = par_en_in ? ((fr_base & ~pmask) | (tx_pbit ? pmask : 12'h000))
                                   : fr_base;
    wire [3:0] fr_len = nbits + 4'h2 + {3'b000, par_en_in} + {3'b000, two_stop_in};

    // Sample tick divider and input synchroniser
    always_ff @(posedge clk_in) begin
        div_r <= (rst_in | tick) ? div_in : div_r - 12'h001; // R1
        sync_r <= rst_in ? 2'b11 : {sync_r[0], rxd_in};
    end

    // Receive state machine, 16 ticks per bit
    always_ff @(posedge clk_in) begin
        if (rst_in || !rx_en) begin
            rx_r <= RX_IDLE;
            rsub_r <= 4'h0;
            rbit_r <= 4'h0;
            sh_r <= 9'h000;
            blind_r <= 1'b0;
        end else if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (half_in && tx_busy) begin
                blind_r <= 1'b1; // R11
            end
            case (rx_r)
                RX_IDLE: begin
                    rsub_r <= 4'h0;
                    blind_r <= half_in & tx_busy; // R11
                    if (!rxd) begin
                        rx_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rsub_r == mux_pkg::MID_START) begin
                        rsub_r <= 4'h0;
                        rbit_r <= 4'h0;
                        rx_r <= rxd ? RX_IDLE : RX_DATA; // R2
                    end
                end
                RX_DATA: begin
                    if (rsub_r == mux_pkg::BIT_END) begin
                        sh_r[rbit_r] <= rxd; // R3 R16
                        rbit_r <= rbit_r + 4'h1;
                        if (rbit_r == last_bit) begin
                            rx_r <= RX_STOP; // R4
                        end
                    end
                end
                RX_STOP: begin
                    if (rsub_r == mux_pkg::BIT_END) begin
                        rx_r <= RX_IDLE;
                    end
                end
                default: rx_r <= RX_IDLE;
            endcase
        end
    end

    // Receive holding buffer; a new character wins over the scanner's clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdy_r <= 1'b0;
            data_r <= 8'h00;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else if (rx_take) begin
            rdy_r <= 1'b1;
            data_r <= rx_dm;
            perr_r <= rx_perr; // R5
            ferr_r <= ~rxd;
        end else if (rx_ack_in) begin
            rdy_r <= 1'b0;
        end
    end

    // Transmit holding buffer and shifter; idle line marks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_r <= TX_IDLE;
            tsub_r <= 4'h0;
            left_r <= 4'h0;
            fr_r <= 12'hFFF;
            full_r <= 1'b0;
            hold_r <= 8'h00;
        end else begin
            if (tx_load_in && !full_r) begin
                full_r <= 1'b1;
                hold_r <= tx_data_in;
            end else if (tx_start) begin
                full_r <= 1'b0;
            end
            if (tx_start) begin
                tx_r <= TX_SHIFT; // R14 R18
                tsub_r <= 4'h0;
                fr_r <= fr_new; // R15 R17
                left_r <= fr_len;
            end else if (bit_end) begin
                tsub_r <= 4'h0;
                fr_r <= {1'b1, fr_r[11:1]}; // R16
                left_r <= left_r - 4'h1;
                if (left_r == 4'h1) begin
                    tx_r <= TX_IDLE; // R13
                end
            end else if (tx_busy && tick) begin
                tsub_r <= tsub_r + 4'h1;
            end
        end
    end

    assign txd_out = tx_busy ? fr_r[0] : 1'b1; // R13
    assign rx_rdy_out = rdy_r;
    assign rx_data_out = data_r;
    assign rx_perr_out = perr_r;
    assign rx_ferr_out = ferr_r;
    assign tx_empty_out = ~full_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    idle_marks_a: assert property (!tx_busy || (bit_end && left_r == 4'h1) |-> txd_out) // R13
        else $error("idle transmitter not marking");
    start_prompt_a: assert property ((tx_r == TX_IDLE) && full_r && en_in |=> !txd_out) // R14
        else $error("start bit not begun promptly");
    false_start_a: assert property ((rx_r == RX_START) && tick && rsub_r == mux_pkg::MID_START
        && rxd |=> rx_r == RX_IDLE) // R2
        else $error("false start not rejected");
    blind_drop_a: assert property (rx_done && blind_r && !rdy_r |=> !rdy_r) // R11
        else $error("own half duplex character kept");
endmodule : line_uart

/* File: rtl/async_mux_line_uart_silo.sv */
// Eight-line serial multiplexer receive silo, scanners and APB registers
// Summary of operation
// R1: Each receiver samples its line with a tick at sixteen times the bit rate.
// R2: After a falling edge, wait eight ticks; marking again means return to idle.
// R3: A space mid start bit begins capture, sampling every sixteen ticks after.
// R4: Samples per character equal character length plus one when parity enabled.
// R5: With parity on, received parity is checked and an error flag set on mismatch.
// R6: Each line keeps its own length, parity and stop settings from its format register.
// R7: A scanner polls receivers and moves characters with status into the silo.
// R8: Receive servicing is granted before transmit servicing, which waits.
// R9: Silo holds 49 sixteen-bit entries; new entries fill the lowest free slot.
// R10: Reading the head word returns and removes it; the rest shift down.
// R11: Half-duplex receivers stay on but drop characters sent during own transmit.
// R12: The remote sender keeps accumulated timing error below 43.75 percent.
// R13: An idle transmitter holds its output marking.
// R14: A loaded idle transmitter begins its start bit within a sixteenth bit.
// R15: Frame is start, five to eight data bits, optional parity, then stop bits.
// R16: Data bits go out and come in least significant bit first.
// R17: Stop bit count follows the line format; one or two are selectable.
// R18: A refilled holding buffer starts its frame straight after the stop bits.
// R19: Per line drive ready, request and secondary outputs; watch four modem inputs.
// R20: After reset a self-test runs before normal operation begins.
// R21: After reset all buffers are empty and every line is disabled.
// R22: Software writes a line's format register before enabling that line.
// R23: With the silo full, characters stay in their receivers untouched.
// R24: Each entry carries character, line number and error flags.
module async_mux_line_uart_silo #(
    parameter int LINES = mux_pkg::LINES,
    parameter int FIFO_DEPTH = mux_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Serial lines
    input wire logic [LINES-1:0] rxd_in,
    output logic [LINES-1:0] txd_out,
    // Modem control outputs
    output logic [LINES-1:0] term_ready_out,
    output logic [LINES-1:0] req_send_out,
    output logic [LINES-1:0] sec_tx_out,
    // Modem status inputs
    input wire logic [LINES-1:0] clear_send_in,
    input wire logic [LINES-1:0] carrier_in,
    input wire logic [LINES-1:0] sec_rx_in,
    input wire logic [LINES-1:0] ring_in
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    generate
        if (LINES != 8 || FIFO_DEPTH < 2 || FIFO_DEPTH > 63) begin : g_check
            $error("unsupported line count or silo depth");
        end
    endgenerate

    typedef logic [mux_pkg::WORD_W-1:0] word_t;

    // Silo storage and control state
    word_t fifo_r [FIFO_DEPTH];
    logic [CW-1:0] count_r;
    logic [5:0] test_r;
    logic testing_r;
    logic [2:0] scan_r;
    logic [LINES-1:0] enable_r;
    logic [mux_pkg::FMT_W-1:0] fmt_r [LINES];
    logic tx_pend_r;
    logic [2:0] tx_line_r;
    logic [7:0] tx_char_r;
    logic [LINES-1:0] dtr_r;
    logic [LINES-1:0] rts_r;
    logic [LINES-1:0] sec_r;
    logic [31:0] prdata_r;
    logic [4*LINES-1:0] msync1_r;
    logic [4*LINES-1:0] msync2_r;

    // Per-line UART inputs and outputs
    logic [LINES-1:0] rx_rdy;
    logic [LINES-1:0] rx_ack;
    logic [LINES-1:0] rx_perr;
    logic [LINES-1:0] rx_ferr;
    logic [7:0] rx_data [LINES];
    logic [LINES-1:0] tx_load;
    logic [LINES-1:0] tx_empty;

    // Bus decode
    wire setup = psel_in & ~penable_in;
    wire access = psel_in & penable_in;
    wire wr = access & pwrite_in & ~testing_r;
    wire hit_en = (paddr_in == mux_pkg::OFF_ENABLE);
    wire hit_fmt = (paddr_in == mux_pkg::OFF_FORMAT);
    wire hit_rx = (paddr_in == mux_pkg::OFF_RXWORD);
    wire hit_tx = (paddr_in == mux_pkg::OFF_TXDATA);
    wire hit_mo = (paddr_in == mux_pkg::OFF_MODEM_OUT);
    wire hit_mi = (paddr_in == mux_pkg::OFF_MODEM_IN);
    wire hit_st = (paddr_in == mux_pkg::OFF_STATUS);
    wire mapped = hit_en | hit_fmt | hit_rx | hit_tx | hit_mo | hit_mi | hit_st;
    wire [2:0] fmt_line = pwdata_in[2:0];

    // Silo movement; pop only a word the setup cycle captured, never a late arrival
    wire full = (count_r == CW'(FIFO_DEPTH));
    wire empty = (count_r == '0);
    wire pop = access & ~pwrite_in & hit_rx & prdata_r[mux_pkg::E_VALID] & ~testing_r; // R10
    wire push = ~testing_r & rx_rdy[scan_r] & (~full | pop); // R7 R23
    wire [CW-1:0] slot = pop ? count_r - CW'(1) : count_r; // R9
    wire word_t entry = {1'b0, 2'b00, rx_ferr[scan_r], rx_perr[scan_r], scan_r,
                         rx_data[scan_r]}; // R24
    wire word_t head = empty ? '0 : (fifo_r[0] | word_t'(1) << mux_pkg::E_VALID);
    wire tx_go = tx_pend_r & ~push & tx_empty[tx_line_r]; // R8

    // Read data mux
    wire [31:0] status = {23'h000000, tx_pend_r, testing_r, full, 6'(count_r)};
    wire [31:0] modem_in = {msync2_r[4*LINES-1:0]};
    wire [31:0] modem_out = {8'h00, sec_r, rts_r, dtr_r};
    wire [31:0] rd_mux = hit_en ? {24'h000000, enable_r} :
                         hit_rx ? {16'h0000, head} :
                         hit_mo ? modem_out :
                         hit_mi ? modem_in :
                         hit_st ? status : 32'h00000000;

    // Eight line UARTs, each with its own stored format
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            line_uart u_uart (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .div_in(fmt_r[gi][mux_pkg::F_DIV +: mux_pkg::DIV_W]),
                .len_in(fmt_r[gi][mux_pkg::F_LEN +: 2]),
                .par_en_in(fmt_r[gi][mux_pkg::F_PEN]),
                .par_odd_in(fmt_r[gi][mux_pkg::F_ODD]),
                .two_stop_in(fmt_r[gi][mux_pkg::F_TWO]),
                .half_in(fmt_r[gi][mux_pkg::F_HALF]),
                .en_in(enable_r[gi]),
                .rxd_in(rxd_in[gi]),
                .txd_out(txd_out[gi]),
                .rx_ack_in(rx_ack[gi]),
                .rx_rdy_out(rx_rdy[gi]),
                .rx_data_out(rx_data[gi]),
                .rx_perr_out(rx_perr[gi]),
                .rx_ferr_out(rx_ferr[gi]),
                .tx_load_in(tx_load[gi]),
                .tx_data_in(tx_char_r),
                .tx_empty_out(tx_empty[gi])
            ); // R6
            assign rx_ack[gi] = push & (scan_r == 3'(gi));
            assign tx_load[gi] = tx_go & (tx_line_r == 3'(gi));
        end
    endgenerate

    // Self-test sweeps every silo slot clean before normal operation
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            testing_r <= 1'b1; // R20
            test_r <= 6'h00;
        end else if (testing_r) begin
            test_r <= test_r + 6'h01;
            testing_r <= (test_r != 6'(FIFO_DEPTH - 1));
        end
    end

    // Silo shift register; hold position when the scanner waits on a full silo
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_r <= '0; // R21
        end else begin
            count_r <= count_r + CW'(push) - CW'(pop);
        end
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            if (testing_r && test_r == 6'(i)) begin
                fifo_r[i] <= '0;
            end else if (push && slot == CW'(i)) begin
                fifo_r[i] <= entry; // R9
            end else if (pop && i < FIFO_DEPTH - 1) begin
                fifo_r[i] <= fifo_r[i + 1]; // R10
            end
        end
    end

    // Round-robin scan pointer; stays while it is taking a character
    always_ff @(posedge clk_in) begin
        scan_r <= rst_in ? 3'h0 : scan_r + {2'b00, ~push}; // R7
    end

    // Line enables and formats
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_r <= '0; // R21
            for (int i = 0; i < LINES; i++) begin
                fmt_r[i] <= '0;
            end
        end else begin
            if (wr && hit_en) begin
                enable_r <= pwdata_in[LINES-1:0];
            end
            if (wr && hit_fmt) begin
                fmt_r[fmt_line] <= pwdata_in[mux_pkg::FMT_LSB +: mux_pkg::FMT_W]; // R6
            end
        end
    end

    // Transmit request waits behind receive servicing; busy writes are dropped
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_pend_r <= 1'b0;
            tx_line_r <= 3'h0;
            tx_char_r <= 8'h00;
        end else if (tx_go) begin
            tx_pend_r <= 1'b0; // R8
        end else if (wr && hit_tx && !tx_pend_r) begin
            tx_pend_r <= 1'b1;
            tx_line_r <= pwdata_in[2:0];
            tx_char_r <= pwdata_in[mux_pkg::TX_CHAR +: 8];
        end
    end

    // Modem outputs and synchronised modem inputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dtr_r <= '0;
            rts_r <= '0;
            sec_r <= '0;
            msync1_r <= '0;
            msync2_r <= '0;
        end else begin
            if (wr && hit_mo) begin
                dtr_r <= pwdata_in[mux_pkg::M_DTR +: LINES]; // R19
                rts_r <= pwdata_in[mux_pkg::M_RTS +: LINES];
                sec_r <= pwdata_in[mux_pkg::M_SEC +: LINES];
            end
            msync1_r <= {ring_in, sec_rx_in, carrier_in, clear_send_in}; // R19
            msync2_r <= msync1_r;
        end
    end

    // Read data captured in the setup cycle, so the pop lands on completion
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = access;
    assign pslverr_out = access & ~mapped;
    assign term_ready_out = dtr_r;
    assign req_send_out = rts_r;
    assign sec_tx_out = sec_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    full_hold_a: assert property (full && !pop |-> !push) // R23
        else $error("push into full silo");
    pop_shift_a: assert property (pop && !push && count_r > CW'(1) |=>
        fifo_r[0] == $past(fifo_r[1]) && count_r == $past(count_r) - CW'(1)) // R10
        else $error("silo did not shift down");
    push_slot_a: assert property (push && !pop |=>
        fifo_r[$past(count_r)] == $past(entry)) // R9
        else $error("entry not at lowest free slot");
    rx_first_a: assert property (push |-> !(|tx_load)) // R8
        else $error("transmit serviced over receive");
    test_len_a: assert property ($fell(rst_in) |-> testing_r [*8]) // R20
        else $error("self-test cut short");
    reset_clear_a: assert property ($past(rst_in) |-> count_r == '0 && enable_r == '0) // R21
        else $error("reset left state behind");
    cov_push_c: cover property (push ##1 pop);
    cov_full_c: cover property (full && rx_rdy[scan_r]);
    cov_tx_c: cover property (tx_pend_r && push ##1 tx_go);
endmodule : async_mux_line_uart_silo

/* File: bench/term_model.sv */
// Serial terminal model: sends frames on rxd and decodes line 2 from txd
module term_model (
    // Clock
    input wire logic clk_in,
    // Serial lines
    input wire logic [7:0] txd_in,
    output logic [7:0] rxd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    logic [7:0] got[$];
    int starts[$];
    initial rxd_out = 8'hFF;
    // Cycle stamp for frame timing
    always @(posedge clk_in) cyc <= cyc + 1;
    // Exact bit length, so no rate error accumulates
    task automatic send(input int ln, input logic [10:0] bits, input int n, input int bl);
        for (int i = 0; i < n; i++) begin
            rxd_out[ln] <= bits[i];
            repeat (bl) @(posedge clk_in);
        end
    endtask : send
    // Short space, too brief to be a start bit
    task automatic glitch(input int ln);
        rxd_out[ln] <= 1'b0;
        repeat (4) @(posedge clk_in);
        rxd_out[ln] <= 1'b1;
    endtask : glitch
    // Mid-bit sampling keeps clear of the edge-aligned transitions
    initial begin
        logic [7:0] ch;
        forever begin
            @(negedge txd_in[2]);
            starts.push_back(cyc);
            repeat (8) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge clk_in);
                ch[i] = txd_in[2];
            end
            repeat (16) @(posedge clk_in);
            if (txd_in[2] === 1'b1) got.push_back(ch);
        end
    end
endmodule : term_model

/* File: bench/async_mux_line_uart_silo_tb.sv */
// Self-checking bench for the serial multiplexer receive silo
module async_mux_line_uart_silo_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00, rxd, txd, trdy, rts, stx;
    logic [7:0] cts = 8'h00, car = 8'h00, srx = 8'h00, ring = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    int n_errors = 0, cmp_count = 0, t0;
    // 20 MHz clock
    always #25 clk_in = ~clk_in;
    async_mux_line_uart_silo dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
        .txd_out(txd), .term_ready_out(trdy), .req_send_out(rts), .sec_tx_out(stx),
        .clear_send_in(cts), .carrier_in(car), .sec_rx_in(srx), .ring_in(ring));
    term_model term_u (.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    // Line 2 frame, 8 data bits, even parity unless spoiled
    task automatic rx(input logic [7:0] ch, input logic bad, input int bl);
        term_u.send(2, {1'b1, ^ch ^ bad, ch, 1'b0}, 11, bl);
        repeat (20) @(posedge clk_in);
    endtask : rx
    task automatic t_reset();
        apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[7], 1'b1);
        check(txd, 8'hFF);
        check({stx, rts, trdy}, 24'h000000);
        for (int i = 0; i < 30 && q[7] !== 1'b0; i++) apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[8:0], 9'h000);
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h0);
    endtask : t_reset
    task automatic t_rx();
        apb(1'b1, mux_pkg::OFF_FORMAT, 32'h0000023A);
        apb(1'b1, mux_pkg::OFF_ENABLE, 32'h00000004);
        rx(8'hA5, 1'b0, 32);
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h000082A5);
        apb(1'b1, mux_pkg::OFF_FORMAT, 32'h00000062);
        term_u.send(2, {4'hF, 1'b0, 5'h15, 1'b0}, 8, 16);
        repeat (20) @(posedge clk_in);
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h00008215);
        apb(1'b1, mux_pkg::OFF_FORMAT, 32'h0000003A);
        rx(8'h3C, 1'b1, 16);
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h00008A3C);
        term_u.glitch(2);
        repeat (40) @(posedge clk_in);
        apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[8:0], 9'h000);
    endtask : t_rx
    task automatic t_fill();
        for (int i = 0; i < 50; i++) rx(8'(i), 1'b0, 16);
        apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[6:0], 7'h71);
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h00008200);
        repeat (20) @(posedge clk_in);
        apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[6:0], 7'h71);
        for (int i = 1; i < 50; i++) begin
            apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
            check(q, 32'h00008200 | 32'(i));
        end
        apb(1'b0, mux_pkg::OFF_RXWORD, 32'h0);
        check(q, 32'h0);
    endtask : t_fill
    task automatic t_tx();
        apb(1'b1, mux_pkg::OFF_FORMAT, 32'h0000009A);
        t0 = term_u.cyc;
        apb(1'b1, mux_pkg::OFF_TXDATA, 32'h00005A02);
        repeat (4) @(posedge clk_in);
        check(term_u.starts.size(), 1);
        check(term_u.starts[0] - t0 <= 5, 1'b1);
        q = 32'h100;
        for (int i = 0; i < 20 && q[8] !== 1'b0; i++) apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, mux_pkg::OFF_TXDATA, 32'h0000C302);
        repeat (400) @(posedge clk_in);
        check(term_u.got.size(), 2);
        check(term_u.got[0], 8'h5A);
        check(term_u.got[1], 8'hC3);
        check(term_u.starts[1] - term_u.starts[0], 176);
        check(txd, 8'hFF);
    endtask : t_tx
    // Own frame on the shared circuit while transmitting must not reach the silo
    task automatic t_half();
        apb(1'b1, mux_pkg::OFF_FORMAT, 32'h0000013A);
        fork
            rx(8'h77, 1'b0, 16);
            apb(1'b1, mux_pkg::OFF_TXDATA, 32'h00007702);
        join
        apb(1'b0, mux_pkg::OFF_STATUS, 32'h0);
        check(q[5:0], 6'h00);
    endtask : t_half
    task automatic t_modem();
        apb(1'b1, mux_pkg::OFF_MODEM_OUT, 32'h00030201);
        check({stx, rts, trdy}, 24'h030201);
        cts <= 8'h11;
        car <= 8'h22;
        srx <= 8'h44;
        ring <= 8'h88;
        repeat (4) @(posedge clk_in);
        apb(1'b0, mux_pkg::OFF_MODEM_IN, 32'h0);
        check(q, 32'h88442211);
        apb(1'b0, 8'h1C, 32'h0);
        check(e, 1'b1);
        check(q, 32'h0);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check({stx, rts, trdy}, 24'h000000);
        apb(1'b0, mux_pkg::OFF_ENABLE, 32'h0);
        check(q, 32'h0);
    endtask : t_modem
    task automatic tally_and_finish();
        $display("errors %0d in %0d compares", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence after an eight-cycle reset
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_rx();
        t_fill();
        t_tx();
        t_half();
        t_modem();
        tally_and_finish();
    end
    // Watchdog well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge clk_in);
        n_errors++;
        tally_and_finish();
    end
endmodule : async_mux_line_uart_silo_tb
